// ===== logic/cdsl_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CDSL_CFG_SVH
`define CDSL_CFG_SVH
`define CDSL_ADDR_STATUS     6'h00
`define CDSL_ADDR_REFDIV     6'h04
`define CDSL_ADDR_CTRL       6'h08
`define CDSL_ADDR_CH0        6'h10
`define CDSL_ADDR_STEP       6'h04
`define CDSL_REF_FORCE_BIT   16
`define CDSL_CTRL_PLL_PD_BIT 5
`define CDSL_CTRL_SRC_BIT    6
`define CDSL_CTRL_SE_BIT     7
`define CDSL_CTRL_ST1_LSB    8
`define CDSL_CTRL_ST2_LSB    12
`define CDSL_CH_DLY_LSB      8
`define CDSL_REF_RATIO_RST   10'h001
`define CDSL_CFG_RST         {{5{6'h01}}, 30'h0000_0000, 5'h00, 1'b0}
`define CDSL_CLK_MHZ         100
`define CDSL_PRESENCE_NS     2000
`define CDSL_PRESENCE_CYC    ((`CDSL_PRESENCE_NS * `CDSL_CLK_MHZ) / 1000)
`endif

// ===== logic/cdsl_core.sv
// Clock divider, channel dividers and status logic with Avalon-MM registers
`include "cdsl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cdsl_core #(
  parameter int NUM_CH = 5
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        vco_clk,
  input  wire logic        ref_in,
  input  wire logic        sync_in,
  input  wire logic        lock_in,
  input  wire logic        clamp_in,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             phase_detector_pulse,
  output logic             pll_powered_down,
  output logic             fifth_single_ended,
  output logic             status_pin_one,
  output logic             status_pin_two,
  output logic [4:0]       ch_out
);
  localparam int PRES = `CDSL_PRESENCE_CYC;

  if (NUM_CH != 5) begin : g_bad_num_ch
    $error("cdsl_core: register map serves exactly five channels");
  end

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge_be

  function automatic logic stat_pick(input logic [2:0] sel,
                                     input cdsl_pkg::cdsl_status_t st);
    logic r;
    r = 1'b0;
    unique case (cdsl_pkg::cdsl_stat_sel_t'(sel))
      cdsl_pkg::CDSL_ST_REF_ABS: r = st.ref_abs;
      cdsl_pkg::CDSL_ST_VCO_ABS: r = st.vco_abs;
      cdsl_pkg::CDSL_ST_LOCK:    r = st.lock;
      cdsl_pkg::CDSL_ST_CLAMP:   r = st.clamp;
      cdsl_pkg::CDSL_ST_ANY_ABS: r = st.ref_abs | st.vco_abs;
      cdsl_pkg::CDSL_ST_ALARM:   r = st.ref_abs | st.vco_abs | ~st.lock | st.clamp;
      cdsl_pkg::CDSL_ST_UNLOCK:  r = ~st.lock;
      cdsl_pkg::CDSL_ST_LOW:     r = 1'b0;
    endcase
    return r;
  endfunction : stat_pick

  // ---------------- bus clock domain ----------------
  logic [4:0]             c_s0, c_s1, c_s2, c_lvl;
  logic                   ref_prev, vbeat_prev, ref_rise;
  logic [1:0]             edge_seen, absent;
  logic [15:0]            abs_cnt [2];
  cdsl_pkg::cdsl_status_t status;
  cdsl_pkg::cdsl_ch_cfg_t cfg, next_cfg;
  logic [9:0]             ref_ratio, ref_eff, rcnt;
  logic                   force_load, ref_div_tgl, req_tgl, busy, acc, cfg_wr;
  logic [2:0]             st1_sel, st2_sel;
  logic [31:0]            reg_rd, wnew;
  logic                   vbeat, ack_tgl;

  // Pin inputs and the handshake ack pass three flops; a level counts once stages agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      c_s0  <= 5'h00;
      c_s1  <= 5'h00;
      c_s2  <= 5'h00;
      c_lvl <= 5'h00;
    end else begin
      c_s0  <= {ack_tgl, clamp_in, lock_in, vbeat, ref_in};
      c_s1  <= c_s0;
      c_s2  <= c_s1;
      c_lvl <= (c_lvl & (c_s1 ^ c_s2)) | (c_s2 & ~(c_s1 ^ c_s2));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ref_prev   <= 1'b0;
      vbeat_prev <= 1'b0;
    end else begin
      ref_prev   <= c_lvl[0];
      vbeat_prev <= c_lvl[1];
    end
  end

  assign ref_rise     = c_lvl[0] & ~ref_prev;
  assign edge_seen[0] = ref_rise;
  assign edge_seen[1] = c_lvl[1] ^ vbeat_prev;
  assign busy         = req_tgl ^ c_lvl[4];

  // presence timeout per input; absent after PRES cycles without an edge
  // the VCO side watches a beat that toggles on every rising VCO edge
  for (genvar d = 0; d < 2; d++) begin : g_presence
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        abs_cnt[d] <= 16'h0000;
        absent[d]  <= 1'b1;
      end else if (edge_seen[d]) begin
        abs_cnt[d] <= 16'h0000;
        absent[d]  <= 1'b0;
      end else if (abs_cnt[d] == 16'(PRES - 1)) begin
        absent[d]  <= 1'b1;
      end else begin
        abs_cnt[d] <= abs_cnt[d] + 16'h0001;
      end
    end
  end

  assign status = '{clamp: c_lvl[3], lock: c_lvl[2], vco_abs: absent[1], ref_abs: absent[0]};

  // register decode; unmapped addresses read zero and ignore writes
  always_comb begin
    reg_rd = 32'h0000_0000;
    if (address == `CDSL_ADDR_STATUS) begin
      reg_rd = {28'h000_0000, status};
    end else if (address == `CDSL_ADDR_REFDIV) begin
      reg_rd = {15'h0000, force_load, 6'h00, ref_ratio};
    end else if (address == `CDSL_ADDR_CTRL) begin
      reg_rd = {17'h0_0000, st2_sel, 1'b0, st1_sel, fifth_single_ended,
                cfg.src_ref, pll_powered_down, cfg.pd};
    end
    for (int i = 0; i < 5; i++) begin
      if (address == 6'(`CDSL_ADDR_CH0 + `CDSL_ADDR_STEP * i)) begin
        reg_rd = {18'h0_0000, cfg.delay[i], 2'b00, cfg.ratio[i]};
      end
    end
  end

  assign wnew = merge_be(reg_rd, writedata, byteenable);
  // a write takes effect only at the edge where waitrequest is seen low
  assign acc  = write & ~waitrequest;

  always_comb begin
    next_cfg = cfg;
    cfg_wr   = 1'b0;
    if (acc && address == `CDSL_ADDR_CTRL) begin
      next_cfg.pd      = wnew[4:0];
      next_cfg.src_ref = wnew[`CDSL_CTRL_SRC_BIT];
      cfg_wr           = 1'b1;
    end
    for (int i = 0; i < 5; i++) begin
      if (acc && address == 6'(`CDSL_ADDR_CH0 + `CDSL_ADDR_STEP * i)) begin
        next_cfg.ratio[i] = wnew[5:0];
        next_cfg.delay[i] = wnew[`CDSL_CH_DLY_LSB +: 6];
        cfg_wr            = 1'b1;
      end
    end
  end

  // one wait cycle, then a single low cycle; writes stall while a handshake is open
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (waitrequest) begin
      waitrequest <= ~(read | (write & ~busy));
      if (read) begin
        readdata <= reg_rd;
      end
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // Channel settings are only rewritten when the VCO side has acked, so they are stable there
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg     <= `CDSL_CFG_RST;
      req_tgl <= 1'b0;
    end else begin
      cfg <= next_cfg;
      if (cfg_wr) begin
        req_tgl <= ~req_tgl;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ref_ratio          <= `CDSL_REF_RATIO_RST;
      force_load         <= 1'b0;
      pll_powered_down   <= 1'b0;
      fifth_single_ended <= 1'b0;
      st1_sel            <= 3'h0;
      st2_sel            <= 3'h0;
    end else if (acc && address == `CDSL_ADDR_REFDIV) begin
      ref_ratio          <= wnew[9:0];
      force_load         <= wnew[`CDSL_REF_FORCE_BIT];
    end else if (acc && address == `CDSL_ADDR_CTRL) begin
      // loop power-down leaves the channel dividers running
      pll_powered_down   <= wnew[`CDSL_CTRL_PLL_PD_BIT];
      fifth_single_ended <= wnew[`CDSL_CTRL_SE_BIT];
      st1_sel            <= wnew[`CDSL_CTRL_ST1_LSB +: 3];
      st2_sel            <= wnew[`CDSL_CTRL_ST2_LSB +: 3];
    end
  end

  // a zero ratio is served as one so the divider never stalls
  assign ref_eff = (ref_ratio == 10'h000) ? 10'h001 : ref_ratio;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rcnt                 <= `CDSL_REF_RATIO_RST;
      phase_detector_pulse <= 1'b0;
      ref_div_tgl          <= 1'b0;
    end else begin
      phase_detector_pulse <= 1'b0;
      // force-load holds the divider at the programmed ratio
      if (force_load || pll_powered_down) begin
        rcnt <= ref_eff;
      end else if (ref_rise) begin
        // the new ratio is picked up at terminal count, or at once while force-load or loop power-down is set
        if (rcnt <= 10'h001) begin
          rcnt                 <= ref_eff;
          phase_detector_pulse <= 1'b1;
          ref_div_tgl          <= ~ref_div_tgl;
        end else begin
          rcnt <= rcnt - 10'h001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_pin_one <= 1'b0;
      status_pin_two <= 1'b0;
    end else begin
      status_pin_one <= stat_pick(st1_sel, status);
      status_pin_two <= stat_pick(st2_sel, status);
    end
  end

  // ---------------- VCO domain ----------------
  logic [2:0]             vrst, v_s0, v_s1, v_s2, v_lvl;
  logic                   v_rst_n, sync_prev, sync_rise, cfg_take, v_reload;
  cdsl_pkg::cdsl_ch_cfg_t vcfg;
  logic [4:0]             chan_o;

  always_ff @(posedge vco_clk) begin
    vrst <= {vrst[1:0], reset_n};
  end
  assign v_rst_n = vrst[2];

  always_ff @(posedge vco_clk) begin
    if (!v_rst_n) begin
      v_s0  <= 3'h0;
      v_s1  <= 3'h0;
      v_s2  <= 3'h0;
      v_lvl <= 3'h0;
    end else begin
      v_s0  <= {ref_div_tgl, sync_in, req_tgl};
      v_s1  <= v_s0;
      v_s2  <= v_s1;
      v_lvl <= (v_lvl & (v_s1 ^ v_s2)) | (v_s2 & ~(v_s1 ^ v_s2));
    end
  end

  assign cfg_take  = v_lvl[0] ^ ack_tgl;
  // a rising sync edge restarts every channel together
  assign sync_rise = v_lvl[1] & ~sync_prev;

  always_ff @(posedge vco_clk) begin
    if (!v_rst_n) begin
      vcfg      <= `CDSL_CFG_RST;
      ack_tgl   <= 1'b0;
      sync_prev <= 1'b0;
      v_reload  <= 1'b1;
      vbeat     <= 1'b0;
    end else begin
      sync_prev <= v_lvl[1];
      v_reload  <= cfg_take | sync_rise;
      vbeat     <= ~vbeat;
      if (cfg_take) begin
        vcfg    <= cfg;
        ack_tgl <= v_lvl[0];
      end
    end
  end

  for (genvar g = 0; g < 5; g++) begin : g_ch
    logic [5:0] cnt, dly, n_eff, half, nc;
    logic       run, hi_p, hi_n, run_n;
    assign n_eff = (vcfg.ratio[g] == 6'h00) ? 6'h01 : vcfg.ratio[g];
    assign half  = n_eff >> 1;
    assign nc    = (cnt == n_eff - 6'h01) ? 6'h00 : cnt + 6'h01;
    always_ff @(posedge vco_clk) begin
      // a powered-down channel holds low on its own
      if (!v_rst_n || v_reload || vcfg.pd[g]) begin
        run  <= 1'b0;
        cnt  <= 6'h00;
        hi_p <= 1'b0;
        dly  <= vcfg.delay[g];
      end else if (!run) begin
        // count out the programmed delay before the first edge
        if (dly == 6'h00) begin
          run  <= 1'b1;
          hi_p <= (half != 6'h00);
        end else begin
          dly <= dly - 6'h01;
        end
      end else begin
        cnt  <= nc;
        hi_p <= (nc < half);
      end
    end
    // odd ratios stretch the high phase by half a cycle from the falling edge
    always_ff @(negedge vco_clk) begin
      hi_n  <= hi_p & n_eff[0];
      run_n <= run & (n_eff == 6'h01);
    end
    // Divide-by-one gates the VCO with a level changed only while it is low, so no glitch
    assign chan_o[g] = (n_eff == 6'h01) ? (run_n & vco_clk) : (hi_p | hi_n);
  end

  // the fifth channel may carry the divided reference instead
  assign ch_out = {vcfg.src_ref ? v_lvl[2] : chan_o[4], chan_o[3:0]};

  // ---------------- checks ----------------
  a_wait_release: assert property (@(posedge clk) disable iff (!reset_n)
    !waitrequest |=> waitrequest) else $error("waitrequest low for more than one cycle");
  a_read_answer: assert property (@(posedge clk) disable iff (!reset_n)
    read && waitrequest |=> !waitrequest) else $error("read not answered after one cycle");
  a_write_effect: assert property (@(posedge clk) disable iff (!reset_n)
    acc && address == `CDSL_ADDR_CTRL && byteenable[0]
    |=> pll_powered_down == $past(writedata[5])) else $error("control write lost");
  a_force_hold: assert property (@(posedge clk) disable iff (!reset_n)
    force_load && $past(force_load) |-> !phase_detector_pulse && rcnt == ref_eff)
    else $error("divider moved under force-load");
  a_ref_count: assert property (@(posedge clk) disable iff (!reset_n)
    ref_rise && rcnt > 10'h001 && !force_load && !pll_powered_down
    |=> rcnt == $past(rcnt) - 10'h001 && !phase_detector_pulse)
    else $error("reference count step wrong");
  a_ref_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    phase_detector_pulse |-> $past(ref_rise) && rcnt == $past(ref_eff))
    else $error("pulse without terminal count");
  a_ref_nonzero: assert property (@(posedge clk) disable iff (!reset_n)
    rcnt != 10'h000) else $error("reference count reached zero");
  a_ref_absent: assert property (@(posedge clk) disable iff (!reset_n)
    ref_rise |=> !status.ref_abs) else $error("reference edge left flag set");
  a_vco_absent: assert property (@(posedge clk) disable iff (!reset_n)
    !edge_seen[1] && abs_cnt[1] == 16'(PRES - 1) |=> status.vco_abs)
    else $error("missing VCO not flagged");
  a_stat_pin: assert property (@(posedge clk) disable iff (!reset_n)
    st1_sel == 3'h0 && $stable(st1_sel) |=> status_pin_one == $past(status.ref_abs))
    else $error("status pin one wrong");
  a_pll_pd: assert property (@(posedge clk) disable iff (!reset_n)
    pll_powered_down && $past(pll_powered_down) |-> !phase_detector_pulse)
    else $error("pulse while loop powered down");
  a_ch_pd: assert property (@(posedge vco_clk) disable iff (!v_rst_n)
    vcfg.pd[0] |=> !g_ch[0].hi_p && !g_ch[0].run) else $error("powered-down channel ran");
  a_ch_delay: assert property (@(posedge vco_clk) disable iff (!v_rst_n)
    !g_ch[1].run && g_ch[1].dly != 6'h00 && !v_reload && !vcfg.pd[1]
    |=> !g_ch[1].run) else $error("channel started before delay ended");
  c_pulse: cover property (@(posedge clk) disable iff (!reset_n) phase_detector_pulse);
  c_ref_back: cover property (@(posedge clk) disable iff (!reset_n) $fell(status.ref_abs));
  c_sync: cover property (@(posedge vco_clk) disable iff (!v_rst_n) sync_rise);
endmodule : cdsl_core
`default_nettype wire

// ===== logic/cdsl_pkg.sv
// Types shared by the clock divider and status logic
`default_nettype none
package cdsl_pkg;
  typedef enum logic [2:0] {
    CDSL_ST_REF_ABS, CDSL_ST_VCO_ABS, CDSL_ST_LOCK, CDSL_ST_CLAMP,
    CDSL_ST_ANY_ABS, CDSL_ST_ALARM, CDSL_ST_UNLOCK, CDSL_ST_LOW
  } cdsl_stat_sel_t;
  typedef struct packed {
    logic [4:0][5:0] ratio;
    logic [4:0][5:0] delay;
    logic [4:0]      pd;
    logic            src_ref;
  } cdsl_ch_cfg_t;
  typedef struct packed {
    logic clamp;
    logic lock;
    logic vco_abs;
    logic ref_abs;
  } cdsl_status_t;
endpackage : cdsl_pkg
`default_nettype wire

// ===== test/cdsl_src.sv
// Signal sources standing at the VCO and reference inputs
`timescale 1ns/1ps
`default_nettype none
module cdsl_src (
  input  wire logic vco_en,
  input  wire logic ref_en,
  output var logic  vco_clk,
  output var logic  ref_in
);
  // Odd offsets keep both sources out of phase with the bus clock
  initial begin
    vco_clk = 1'b0;
    #7;
    forever #15 vco_clk = vco_en ? ~vco_clk : 1'b0;
  end
  // A stopped source rests low, as an absent input would
  initial begin
    ref_in = 1'b0;
    #3;
    forever #50 ref_in = ref_en ? ~ref_in : 1'b0;
  end
endmodule : cdsl_src
`default_nettype wire

// ===== test/clock_divider_and_status_logic_test.sv
// Self-checking bench for the clock divider and status logic
`include "cdsl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_divider_and_status_logic_test;
  logic        clk, reset_n, sync_in, lock_in, clamp_in, read, write;
  logic        vco_en, ref_en, vco_clk, ref_in, waitrequest;
  logic        phase_detector_pulse, pll_powered_down, fifth_single_ended;
  logic        status_pin_one, status_pin_two;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [4:0]  ch_out, seen;
  int          errors, compares, cycles, c;
  int          ratio[5] = '{1, 2, 3, 63, 5};
  realtime     t0;

  cdsl_core i_cdsl_core (.clk(clk), .reset_n(reset_n), .vco_clk(vco_clk), .ref_in(ref_in),
    .sync_in(sync_in), .lock_in(lock_in), .clamp_in(clamp_in), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .phase_detector_pulse(phase_detector_pulse),
    .pll_powered_down(pll_powered_down), .fifth_single_ended(fifth_single_ended),
    .status_pin_one(status_pin_one), .status_pin_two(status_pin_two), .ch_out(ch_out));
  cdsl_src i_cdsl_src (.vco_en(vco_en), .ref_en(ref_en), .vco_clk(vco_clk), .ref_in(ref_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cycles++;
    if (cycles == 70000) begin
      errors++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low
  // host frames each access
  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : acc

  // Clock cycles from one divider pulse to the next
  task automatic gap(output int n);
    do @(posedge clk); while (phase_detector_pulse !== 1'b1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (phase_detector_pulse !== 1'b1);
  endtask : gap

  // Period and high time of one channel, in ns
  task automatic shape(input int i, input int per);
    realtime ta, tb;
    wait (ch_out[i] === 1'b0);
    wait (ch_out[i] === 1'b1);
    ta = $realtime;
    wait (ch_out[i] === 1'b0);
    tb = $realtime;
    wait (ch_out[i] === 1'b1);
    chk("period", 32'(int'($realtime - ta)), 32'(per));
    chk("high", 32'(int'(tb - ta)), 32'(per / 2));
  endtask : shape

  // Phase of channel 1 behind channel 0, in ns
  task automatic skew(output int n);
    @(posedge ch_out[0]);
    t0 = $realtime;
    @(posedge ch_out[1]);
    n = int'($realtime - t0);
  endtask : skew

  initial begin
    {reset_n, sync_in, read, write, address, writedata} = '0;
    {lock_in, clamp_in, vco_en, ref_en, byteenable} = 8'hFF;
    // Longer than three cycles: the VCO side needs four of its own edges
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (300) @(posedge clk);
    acc(0, `CDSL_ADDR_STATUS, 0);
    chk("status", rd, 32'h0000_000C);
    ref_en <= 1'b0;
    repeat (300) @(posedge clk);
    acc(0, `CDSL_ADDR_STATUS, 0);
    chk("status", rd, 32'h0000_000D);
    for (int s = 0; s < 8; s++) begin
      acc(1, `CDSL_ADDR_CTRL, 32'(s) << 8 | 32'(s) << 12);
      repeat (4) @(posedge clk);
      chk("pin one", status_pin_one, 1'(8'h3D >> s));
      chk("pin two", status_pin_two, 1'(8'h3D >> s));
    end
    {ref_en, vco_en} <= 2'b10;
    repeat (300) @(posedge clk);
    acc(0, `CDSL_ADDR_STATUS, 0);
    chk("status", rd, 32'h0000_000E);
    vco_en <= 1'b1;
    repeat (300) @(posedge clk);
    acc(0, 6'h3C, 0);
    chk("unmapped", rd, 32'h0);
    acc(1, `CDSL_ADDR_CTRL, 32'h0);
    acc(1, `CDSL_ADDR_REFDIV, 20);
    gap(c);
    gap(c);
    chk("ref gap", c, 200);
    fork
      gap(c);
      begin
        repeat (220) @(posedge clk);
        acc(1, `CDSL_ADDR_REFDIV, 4);
      end
    join
    chk("ref gap", c, 200);
    gap(c);
    chk("ref gap", c, 40);
    acc(1, `CDSL_ADDR_REFDIV, 32'h0001_03FF);
    // A pulse launched at the write edge itself is not a fault
    repeat (2) @(posedge clk);
    seen = '0;
    repeat (200) @(posedge clk) seen[0] |= phase_detector_pulse;
    chk("held", seen[0], 1'b0);
    acc(1, `CDSL_ADDR_REFDIV, 32'h3FF);
    gap(c);
    chk("ref gap", c, 10230);
    acc(1, `CDSL_ADDR_REFDIV, 32'h0001_0003);
    acc(1, `CDSL_ADDR_REFDIV, 32'h3);
    for (int i = 0; i < 5; i++) acc(1, `CDSL_ADDR_CH0 + 6'(4 * i), ratio[i]);
    // Settings reach the channels only after the handshake and reload
    repeat (50) @(posedge clk);
    for (int i = 0; i < 5; i++) shape(i, 30 * ratio[i]);
    acc(1, `CDSL_ADDR_CH0, 20);
    acc(1, `CDSL_ADDR_CH0 + 6'h04, 32'h0714);
    repeat (50) @(posedge clk);
    skew(c);
    chk("delay", c, 210);
    @(posedge clk) sync_in <= 1'b1;
    repeat (20) @(posedge clk);
    sync_in <= 1'b0;
    skew(c);
    chk("delay", c, 210);
    acc(1, `CDSL_ADDR_CTRL, 32'h24);
    repeat (50) @(posedge clk);
    seen = '0;
    repeat (200) @(posedge clk) seen |= {phase_detector_pulse, 1'b0, ch_out[2], 1'b0, ch_out[0]};
    chk("power down", {seen, pll_powered_down}, 6'h03);
    acc(1, `CDSL_ADDR_CTRL, 32'hC0);
    repeat (50) @(posedge clk);
    chk("single ended", fifth_single_ended, 1'b1);
    shape(4, 600);
    conclude();
  end
endmodule : clock_divider_and_status_logic_test
`default_nettype wire
